/* File: rtl/psslc_pkg.sv */
// constants shared by the slot status and link control two register block
package psslc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register indices and byte addresses (byte address is four times the index)
   localparam int ADDR_W = 10;
   localparam logic [7:0] IDX_SLOT_STATUS = 8'h5a;
   localparam logic [7:0] IDX_DEV_CAP2 = 8'h64;
   localparam logic [7:0] IDX_DEV_CTL2 = 8'h68;
   localparam logic [7:0] IDX_DEV_STS2 = 8'h6a;
   localparam logic [7:0] IDX_LINK_CAP2 = 8'h6c;
   localparam logic [7:0] IDX_LINK_CTL2 = 8'h70;
   localparam logic [9:0] ADDR_SLOT_STATUS = {IDX_SLOT_STATUS, 2'b00};
   localparam logic [9:0] ADDR_DEV_CAP2 = {IDX_DEV_CAP2, 2'b00};
   localparam logic [9:0] ADDR_DEV_CTL2 = {IDX_DEV_CTL2, 2'b00};
   localparam logic [9:0] ADDR_DEV_STS2 = {IDX_DEV_STS2, 2'b00};
   localparam logic [9:0] ADDR_LINK_CAP2 = {IDX_LINK_CAP2, 2'b00};
   localparam logic [9:0] ADDR_LINK_CTL2 = {IDX_LINK_CTL2, 2'b00};

   ////////////////////////////////////////////////////////////////////////////
   // slot status field positions
   localparam int BIT_ATTN = 0;
   localparam int BIT_PFAULT = 1;
   localparam int BIT_LATCH_CHG = 2;
   localparam int BIT_PRES_CHG = 3;
   localparam int BIT_CMD_DONE = 4;
   localparam int BIT_LATCH = 5;
   localparam int BIT_PRES = 6;
   localparam int BIT_LOCK = 7;
   localparam int BIT_LINK_CHG = 8;

   // index of each clearable flag in the internal flag vector
   localparam int FLAG_N = 6;
   localparam int FL_ATTN = 0;
   localparam int FL_PFAULT = 1;
   localparam int FL_LATCH = 2;
   localparam int FL_PRES = 3;
   localparam int FL_CMD = 4;
   localparam int FL_LINK = 5;
   localparam logic [5:0] FLAGS_RESET = 6'h00;

   ////////////////////////////////////////////////////////////////////////////
   // link control two fields
   localparam int TLS_LSB = 0;
   localparam int TLS_W = 4;
   localparam int BIT_COMPLY = 4;
   localparam int BIT_AUTO_BLK = 5;
   localparam logic [3:0] SPEED_GEN1 = 4'h1;
   localparam logic [3:0] SPEED_GEN2 = 4'h2;
   localparam logic [3:0] TLS_RESET = SPEED_GEN2;
   localparam logic COMPLY_RESET = 1'b0;
   localparam logic AUTO_BLK_VALUE = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // synchronised pin inputs: attention, power fault, latch, presence, interlock
   localparam int SYN_N = 5;
   localparam int SY_ATTN = 0;
   localparam int SY_PFAULT = 1;
   localparam int SY_LATCH = 2;
   localparam int SY_PRES = 3;
   localparam int SY_LOCK = 4;
   localparam logic [4:0] SYN_RESET = 5'h08;

endpackage

/* File: rtl/psslc_sync_edge.sv */
// two-stage synchronisers with rise and change detection per input bit
`timescale 1ns/1ns
module psslc_sync_edge #(
   parameter int N = 5,
   parameter logic [N-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // asynchronous levels
   input wire logic [N-1:0] async_i,
   // synchronised view
   output logic [N-1:0] level_o,
   output logic [N-1:0] rise_o,
   output logic [N-1:0] change_o
);

   logic [N-1:0] stage1;
   logic [N-1:0] stage2;
   logic [N-1:0] prev;
   logic [2:0] armed;

   // edges are held off until prev holds a real pin sample, so a pin that
   // differs from its reset value raises no false event after reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         armed <= 3'h0;
      end else begin
         armed <= {armed[1:0], 1'b1};
      end
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_bit
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               stage1[g] <= RST_VAL[g];
               stage2[g] <= RST_VAL[g];
               prev[g] <= RST_VAL[g];
            end else begin
               stage1[g] <= async_i[g];
               stage2[g] <= stage1[g];
               prev[g] <= stage2[g];
            end
         end
         assign level_o[g] = stage2[g];
         assign rise_o[g] = stage2[g] & ~prev[g] & armed[2];
         assign change_o[g] = (stage2[g] ^ prev[g]) & armed[2];
      end
   endgenerate

endmodule

/* File: rtl/psslc_cmd_track.sv */
// tracks one slot control command from its write until all actions finish
`timescale 1ns/1ns
module psslc_cmd_track (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic hot_reset_i,
   // command source and action status
   input wire logic cmd_write_i,
   input wire logic actions_busy_i,
   input wire logic actions_done_i,
   // completion pulse
   output logic done_o
);

   logic pending;
   logic next_pending;
   logic finish;

   // completion only once nothing is left outstanding on the expander side
   assign finish = pending & actions_done_i & ~actions_busy_i;

   // a write opens exactly one command, however many fields it touches
   assign next_pending = hot_reset_i ? 1'b0 :
                         cmd_write_i ? 1'b1 :
                         finish ? 1'b0 : pending;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pending <= 1'b0;
      end else begin
         pending <= next_pending;
      end
   end

   assign done_o = finish;

endmodule

/* File: rtl/psslc_top.sv */
// slot status and link control two registers behind an avalon-mm slave
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
module psslc_top (
   // clock and fundamental reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // hot reset from the port, same clock
   input wire logic hot_reset_i,
   // avalon-mm slave
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // slot pins, asynchronous
   input wire logic attention_button_i,
   input wire logic power_fault_i,
   input wire logic latch_open_i,
   input wire logic card_present_i,
   input wire logic interlock_engaged_i,
   // port logic, same clock
   input wire logic link_active_flag_i,
   input wire logic slot_ctl_write_i,
   input wire logic slot_actions_busy_i,
   input wire logic slot_actions_done_i,
   input wire logic downstream_port_i,
   input wire logic retrain_req_i,
   // link control outputs
   output logic [3:0] target_speed_o,
   output logic force_compliance_o,
   output logic [3:0] compliance_speed_o,
   output logic advertise_gen2_o,
   output logic autonomous_speed_block_o,
   output logic speed_change_req_o,
   output logic command_completed_o
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detection
   logic [psslc_pkg::SYN_N-1:0] pins_async;
   logic [psslc_pkg::SYN_N-1:0] pins_level;
   logic [psslc_pkg::SYN_N-1:0] pins_rise;
   logic [psslc_pkg::SYN_N-1:0] pins_change;

   assign pins_async = {interlock_engaged_i, card_present_i, latch_open_i, power_fault_i, attention_button_i};

   psslc_sync_edge #(
      .N(psslc_pkg::SYN_N),
      .RST_VAL(psslc_pkg::SYN_RESET)
   ) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .async_i(pins_async),
      .level_o(pins_level),
      .rise_o(pins_rise),
      .change_o(pins_change)
   );

   ////////////////////////////////////////////////////////////////////////////
   // command tracking
   logic cmd_done;

   psslc_cmd_track u_cmd (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .hot_reset_i(hot_reset_i),
      .cmd_write_i(slot_ctl_write_i),
      .actions_busy_i(slot_actions_busy_i),
      .actions_done_i(slot_actions_done_i),
      .done_o(cmd_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // link active change detection, input already on this clock
   logic link_active_prev;
   logic link_active_chg;

   assign link_active_chg = link_active_flag_i ^ link_active_prev;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         link_active_prev <= 1'b0;
      end else begin
         link_active_prev <= link_active_flag_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: one wait cycle, then the access completes
   logic bus_req;
   logic bus_accept;
   logic next_waitrequest;

   assign bus_req = avs_read_i | avs_write_i;
   assign bus_accept = bus_req & ~avs_waitrequest_o;
   assign next_waitrequest = ~(bus_req & avs_waitrequest_o);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= next_waitrequest;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   logic hit_status;
   logic hit_ctl2;
   logic hit_zero;
   logic wr_status;
   logic wr_ctl2;

   assign hit_status = avs_address_i == psslc_pkg::ADDR_SLOT_STATUS;
   assign hit_ctl2 = avs_address_i == psslc_pkg::ADDR_LINK_CTL2;
   assign hit_zero = (avs_address_i == psslc_pkg::ADDR_DEV_CAP2) |
                     (avs_address_i == psslc_pkg::ADDR_DEV_CTL2) |
                     (avs_address_i == psslc_pkg::ADDR_DEV_STS2) |
                     (avs_address_i == psslc_pkg::ADDR_LINK_CAP2);
   assign wr_status = bus_accept & avs_write_i & hit_status;
   assign wr_ctl2 = bus_accept & avs_write_i & hit_ctl2 & avs_byteenable_i[0];

   ////////////////////////////////////////////////////////////////////////////
   // clearable event flags
   logic [psslc_pkg::FLAG_N-1:0] flags;
   logic [psslc_pkg::FLAG_N-1:0] flag_set;
   logic [psslc_pkg::FLAG_N-1:0] flag_clr;
   logic [psslc_pkg::FLAG_N-1:0] next_flags;
   logic [7:0] clr_lane0;
   logic clr_lane1;

   assign flag_set[psslc_pkg::FL_ATTN] = pins_rise[psslc_pkg::SY_ATTN];
   assign flag_set[psslc_pkg::FL_PFAULT] = pins_rise[psslc_pkg::SY_PFAULT];
   assign flag_set[psslc_pkg::FL_LATCH] = pins_change[psslc_pkg::SY_LATCH];
   assign flag_set[psslc_pkg::FL_PRES] = pins_change[psslc_pkg::SY_PRES];
   assign flag_set[psslc_pkg::FL_CMD] = cmd_done;
   assign flag_set[psslc_pkg::FL_LINK] = link_active_chg;

   assign clr_lane0 = wr_status & avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;
   assign clr_lane1 = wr_status & avs_byteenable_i[1] & avs_writedata_i[psslc_pkg::BIT_LINK_CHG];

   // only ones written clear; zeros leave the flag alone
   assign flag_clr[psslc_pkg::FL_ATTN] = clr_lane0[psslc_pkg::BIT_ATTN];
   assign flag_clr[psslc_pkg::FL_PFAULT] = clr_lane0[psslc_pkg::BIT_PFAULT];
   assign flag_clr[psslc_pkg::FL_LATCH] = clr_lane0[psslc_pkg::BIT_LATCH_CHG];
   assign flag_clr[psslc_pkg::FL_PRES] = clr_lane0[psslc_pkg::BIT_PRES_CHG];
   assign flag_clr[psslc_pkg::FL_CMD] = clr_lane0[psslc_pkg::BIT_CMD_DONE];
   assign flag_clr[psslc_pkg::FL_LINK] = clr_lane1;

   // a new event in the clearing cycle wins; hot reset clears non-sticky flags
   assign next_flags = hot_reset_i ? psslc_pkg::FLAGS_RESET : (flag_set | (flags & ~flag_clr));

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags <= psslc_pkg::FLAGS_RESET;
      end else begin
         flags <= next_flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky link control two fields, cleared only by the fundamental reset
   logic [3:0] target_speed;
   logic comply;
   logic [3:0] next_tls;
   logic next_comply;

   assign next_tls = wr_ctl2 ? avs_writedata_i[psslc_pkg::TLS_LSB +: psslc_pkg::TLS_W] : target_speed;
   assign next_comply = wr_ctl2 ? avs_writedata_i[psslc_pkg::BIT_COMPLY] : comply;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         target_speed <= psslc_pkg::TLS_RESET;
         comply <= psslc_pkg::COMPLY_RESET;
      end else begin
         target_speed <= next_tls;
         comply <= next_comply;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data assembly
   logic [15:0] status_word;
   logic [15:0] ctl2_word;
   logic [31:0] read_mux;

   assign status_word[psslc_pkg::BIT_ATTN] = flags[psslc_pkg::FL_ATTN];
   assign status_word[psslc_pkg::BIT_PFAULT] = flags[psslc_pkg::FL_PFAULT];
   assign status_word[psslc_pkg::BIT_LATCH_CHG] = flags[psslc_pkg::FL_LATCH];
   assign status_word[psslc_pkg::BIT_PRES_CHG] = flags[psslc_pkg::FL_PRES];
   assign status_word[psslc_pkg::BIT_CMD_DONE] = flags[psslc_pkg::FL_CMD];
   assign status_word[psslc_pkg::BIT_LATCH] = pins_level[psslc_pkg::SY_LATCH];
   assign status_word[psslc_pkg::BIT_PRES] = pins_level[psslc_pkg::SY_PRES];
   assign status_word[psslc_pkg::BIT_LOCK] = pins_level[psslc_pkg::SY_LOCK];
   assign status_word[psslc_pkg::BIT_LINK_CHG] = flags[psslc_pkg::FL_LINK];
   assign status_word[15:9] = 7'h00;

   assign ctl2_word[3:0] = target_speed;
   assign ctl2_word[psslc_pkg::BIT_COMPLY] = comply;
   assign ctl2_word[psslc_pkg::BIT_AUTO_BLK] = psslc_pkg::AUTO_BLK_VALUE;
   assign ctl2_word[15:6] = 10'h000;

   // reserved two registers and unmapped addresses return zero
   assign read_mux = hit_status ? {16'h0000, status_word} :
                     hit_ctl2 ? {16'h0000, ctl2_word} :
                     hit_zero ? 32'h0000_0000 : 32'h0000_0000;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i & avs_waitrequest_o) begin
         avs_readdata_o <= read_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link side outputs
   logic next_adv_gen2;

   // downstream ports only advertise 5.0 Gbps when the target allows it
   assign next_adv_gen2 = ~downstream_port_i | (target_speed == psslc_pkg::SPEED_GEN2);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         target_speed_o <= psslc_pkg::TLS_RESET;
         force_compliance_o <= psslc_pkg::COMPLY_RESET;
         compliance_speed_o <= psslc_pkg::TLS_RESET;
         advertise_gen2_o <= 1'b1;
         autonomous_speed_block_o <= psslc_pkg::AUTO_BLK_VALUE;
         speed_change_req_o <= 1'b0;
         command_completed_o <= 1'b0;
      end else begin
         target_speed_o <= target_speed;
         force_compliance_o <= comply;
         compliance_speed_o <= target_speed;
         advertise_gen2_o <= next_adv_gen2;
         autonomous_speed_block_o <= psslc_pkg::AUTO_BLK_VALUE;
         speed_change_req_o <= retrain_req_i;
         command_completed_o <= flags[psslc_pkg::FL_CMD];
      end
   end

endmodule

/* File: dv/psslc_top_assertions.sv */
// concurrent checks on the slot status and link control two register block
`timescale 1ns/1ns
module psslc_top_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // inputs watched
   input wire logic hot_reset_i,
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic downstream_port_i,
   input wire logic retrain_req_i,
   input wire logic slot_actions_busy_i,
   // outputs watched
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [3:0] target_speed_o,
   input wire logic [3:0] compliance_speed_o,
   input wire logic advertise_gen2_o,
   input wire logic autonomous_speed_block_o,
   input wire logic speed_change_req_o,
   input wire logic command_completed_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire req = avs_read_i && avs_waitrequest_o;
   wire wr_done = avs_write_i && !avs_waitrequest_o;
   wire res_rd = req && (avs_address_i == psslc_pkg::ADDR_DEV_CAP2 || avs_address_i == psslc_pkg::ADDR_DEV_CTL2
      || avs_address_i == psslc_pkg::ADDR_DEV_STS2 || avs_address_i == psslc_pkg::ADDR_LINK_CAP2);
   ////////////////////////////////////////
   wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("access not answered after one wait cycle");
   reserved_zero_a: assert property (res_rd |=> avs_readdata_o == 32'h0)
      else $error("reserved register read not zero");
   status_high_a: assert property (req && avs_address_i == psslc_pkg::ADDR_SLOT_STATUS |=> avs_readdata_o[31:9] == 23'h0)
      else $error("slot status upper bits not zero");
   auto_blk_a: assert property (req && avs_address_i == psslc_pkg::ADDR_LINK_CTL2 |=> !avs_readdata_o[5] && !autonomous_speed_block_o)
      else $error("autonomous speed block not zero");
   comply_speed_a: assert property (compliance_speed_o == target_speed_o)
      else $error("compliance speed differs from target speed");
   adv_cap_a: assert property (downstream_port_i && $past(downstream_port_i) && $stable(target_speed_o)
      && target_speed_o != psslc_pkg::SPEED_GEN2 |-> !advertise_gen2_o)
      else $error("downstream port advertises above target speed");
   retrain_a: assert property (retrain_req_i |=> speed_change_req_o)
      else $error("software speed change blocked");
   cmd_wait_a: assert property ($rose(command_completed_o) |-> !$past(slot_actions_busy_i, 2))
      else $error("command completed while actions busy");
   cmd_hold_a: assert property (command_completed_o && !$past(hot_reset_i) && !$past(wr_done) |=> command_completed_o)
      else $error("command completed flag dropped without clear");
   sticky_keep_a: assert property (hot_reset_i |=> $stable(target_speed_o))
      else $error("target speed lost on hot reset");
   cover property (res_rd);
   cover property ($rose(command_completed_o));
   cover property (hot_reset_i ##1 !hot_reset_i);
endmodule

/* File: dv/test_psslc_top.sv */
// self-checking bench for the slot status and link control two register block
`timescale 1ns/1ns
module test_psslc_top;
   logic clk_i, rst_n_i, hot_reset_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [9:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, q;
   logic [3:0] avs_byteenable_i, target_speed_o, compliance_speed_o;
   logic attention_button_i, power_fault_i, latch_open_i, card_present_i, interlock_engaged_i;
   logic link_active_flag_i, slot_ctl_write_i, slot_actions_busy_i, slot_actions_done_i;
   logic downstream_port_i, retrain_req_i, force_compliance_o, advertise_gen2_o;
   logic autonomous_speed_block_o, speed_change_req_o, command_completed_o;
   int errors, compares;
   localparam logic [9:0] SS = psslc_pkg::ADDR_SLOT_STATUS;
   localparam logic [9:0] LC = psslc_pkg::ADDR_LINK_CTL2;
   localparam logic [9:0] RA [5] = '{psslc_pkg::ADDR_DEV_CAP2, psslc_pkg::ADDR_DEV_CTL2,
      psslc_pkg::ADDR_DEV_STS2, psslc_pkg::ADDR_LINK_CAP2, 10'h3fc};
   localparam int BI [7] = '{0, 1, 2, 3, 8, 8, 2};

   psslc_top dut (.clk_i, .rst_n_i, .hot_reset_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .attention_button_i,
      .power_fault_i, .latch_open_i, .card_present_i, .interlock_engaged_i, .link_active_flag_i,
      .slot_ctl_write_i, .slot_actions_busy_i, .slot_actions_done_i, .downstream_port_i, .retrain_req_i,
      .target_speed_o, .force_compliance_o, .compliance_speed_o, .advertise_gen2_o,
      .autonomous_speed_block_o, .speed_change_req_o, .command_completed_o);

   always #5 clk_i = ~clk_i;
   ////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // one avalon access; read data lands in q
   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      @(posedge clk_i);
      while (avs_waitrequest_o !== 1'b0) begin
         n++;
         if (n > 20) begin
            errors++;
            final_report();
         end
         @(posedge clk_i);
      end
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge clk_i);
   endtask

   function automatic logic [31:0] live();
      return {24'h0, interlock_engaged_i, card_present_i, latch_open_i, 5'h0};
   endfunction

   task automatic cmd(input logic w, input logic d);
      slot_ctl_write_i <= w;
      slot_actions_done_i <= d;
      @(posedge clk_i);
      slot_ctl_write_i <= 1'b0;
      slot_actions_done_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      bus(0, SS, 0, 0);
      check(q, 32'h40);
      bus(0, LC, 0, 0);
      check(q, 32'h2);
      foreach (RA[i]) begin
         bus(1, RA[i], 32'hffffffff, 4'hf);
         bus(0, RA[i], 0, 0);
         check(q, 32'h0);
      end
   endtask

   task automatic t_events();
      for (int i = 0; i < 7; i++) begin
         case (i)
            0: attention_button_i <= 1'b1;
            1: power_fault_i <= 1'b1;
            2: latch_open_i <= 1'b1;
            3: card_present_i <= 1'b0;
            4: link_active_flag_i <= 1'b1;
            5: link_active_flag_i <= 1'b0;
            default: latch_open_i <= 1'b0;
         endcase
         repeat (3) @(posedge clk_i);
         bus(1, SS, 32'h0, 4'h3);
         bus(0, SS, 0, 0);
         check(q, live() | (32'h1 << BI[i]));
         bus(1, SS, 32'h1 << BI[i], 4'h3);
         bus(0, SS, 0, 0);
         check(q, live());
      end
      interlock_engaged_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      bus(0, SS, 0, 0);
      check(q, live());
   endtask

   task automatic t_cmd();
      slot_actions_busy_i <= 1'b1;
      cmd(1, 0);
      cmd(0, 1);
      bus(0, SS, 0, 0);
      check(q[4], 1'b0);
      slot_actions_busy_i <= 1'b0;
      cmd(1, 0);
      cmd(0, 1);
      check(command_completed_o, 1'b1);
      bus(1, SS, 32'h10, 4'h3);
      cmd(0, 1);
      bus(0, SS, 0, 0);
      check(q[4], 1'b0);
   endtask

   task automatic t_link();
      bus(1, LC, 32'h31, 4'h2);
      bus(0, LC, 0, 0);
      check(q, 32'h2);
      bus(1, LC, 32'hffffff31, 4'h3);
      bus(0, LC, 0, 0);
      check(q, 32'h11);
      check({force_compliance_o, compliance_speed_o, target_speed_o}, 9'h111);
      downstream_port_i <= 1'b1;
      retrain_req_i <= 1'b1;
      link_active_flag_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      check({advertise_gen2_o, speed_change_req_o, autonomous_speed_block_o}, 3'b010);
      hot_reset_i <= 1'b1;
      @(posedge clk_i);
      hot_reset_i <= 1'b0;
      @(posedge clk_i);
      bus(0, SS, 0, 0);
      check(q, live());
      bus(0, LC, 0, 0);
      check(q, 32'h11);
      rst_n_i <= 1'b0;
      retrain_req_i <= 1'b0;
      link_active_flag_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      bus(0, LC, 0, 0);
      check(q, 32'h2);
      check(advertise_gen2_o, 1'b1);
      bus(0, SS, 0, 0);
      check(q, live());
   endtask
   ////////////////////////////////////////
   initial begin
      {clk_i, rst_n_i, hot_reset_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
      {avs_byteenable_i, attention_button_i, power_fault_i, latch_open_i, interlock_engaged_i} = '0;
      {link_active_flag_i, slot_ctl_write_i, slot_actions_busy_i, slot_actions_done_i} = '0;
      {downstream_port_i, retrain_req_i, errors, compares} = '0;
      card_present_i = 1'b1;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t_reset();
      t_events();
      t_cmd();
      t_link();
      final_report();
   end
endmodule

bind psslc_top psslc_top_checker chk (.clk_i, .rst_n_i, .hot_reset_i, .avs_address_i, .avs_read_i,
   .avs_write_i, .downstream_port_i, .retrain_req_i, .slot_actions_busy_i, .avs_readdata_o,
   .avs_waitrequest_o, .target_speed_o, .compliance_speed_o, .advertise_gen2_o,
   .autonomous_speed_block_o, .speed_change_req_o, .command_completed_o);
